// ---- src/fma_decode_defines.svh ----
// Constants for the SIMD fused multiply-add operand decoder.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FMA_DECODE_DEFINES_SVH
`define FMA_DECODE_DEFINES_SVH

// Instruction fields
`define OP_MSB 31
`define OP_LSB 30
`define OP3_MSB 24
`define OP3_LSB 19
`define RD_MSB 29
`define RD_LSB 25
`define RS1_MSB 18
`define RS1_LSB 14
`define RS3_MSB 13
`define RS3_LSB 9
`define VAR_MSB 8
`define VAR_LSB 7
`define SIZE_MSB 6
`define SIZE_LSB 5
`define RS2_MSB 4
`define RS2_LSB 0
`define OP_FMA 2'h2
`define OP3_FMA 6'h37
`define SIZE_SINGLE 2'h1
`define SIZE_DOUBLE 2'h2
`define SIZE_RSVD 2'h3
`define VAR_RSVD 2'h3
`define PFX_HI 2

// Trap type shown with the miscellaneous float trap
`define TRAP_TYPE_INCOMPLETE 3'h2
`define TRAP_TYPE_NONE 3'h0

// Register map, byte addresses
`define ADDR_W 5
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_MASK 5'h08
`define REG_INFO 5'h0c
`define CTRL_FPEN 0
`define CTRL_TEM_LSB 1
`define CTRL_TEM_MSB 4
`define CTRL_RESET 32'h0000_0001
`define EVT_ILLEGAL 0
`define EVT_FPOFF 1
`define EVT_IEEE 2
`define EVT_MISC 3
`define EVT_W 4

`endif

// ---- src/fma_decode_pkg.sv ----
// Types shared by the SIMD fused multiply-add operand decoder.
// Assumes the defines header is compiled alongside.
package fma_decode_pkg;

  typedef logic [8:0] reg_num_t;

  typedef struct packed {
    logic [2:0] src1_prefix_bits;
    logic [2:0] src2_prefix_bits;
    logic [2:0] src3_prefix_bits;
    logic [2:0] dest_prefix_bits;
  } prefix_s;

  typedef struct packed {
    reg_num_t src1;
    reg_num_t src2;
    reg_num_t src3;
    reg_num_t dest;
  } regs_s;

  typedef struct packed {
    logic neg_product;
    logic sub_addend;
  } lane_op_s;

  typedef struct packed {
    logic nv;
    logic nx;
    logic of_;
    logic uf;
  } ieee_s;

endpackage : fma_decode_pkg

// ---- src/operand_lane_map.sv ----
// Maps one operand's prefix bits and 6-bit field to basic and extended
// lane register numbers. Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "fma_decode_defines.svh"
module operand_lane_map (
  input wire logic [2:0] prefix,
  input wire logic [5:0] field,
  input wire logic simd,
  input wire logic fma,
  input wire logic pair_src,
  output fma_decode_pkg::reg_num_t basic_num,
  output fma_decode_pkg::reg_num_t ext_num
);
  import fma_decode_pkg::*;

  always_comb begin
    if (!simd) begin
      basic_num = {prefix, field};
      ext_num = {prefix, field};
    end else if (fma && pair_src) begin
      basic_num = {prefix, field};
      ext_num = {~prefix[`PFX_HI], prefix[1:0], field};
    end else begin
      // Top prefix bit never selects a register here
      basic_num = {1'b0, prefix[1:0], field};
      ext_num = {1'b1, prefix[1:0], field};
    end
  end

endmodule : operand_lane_map
`default_nettype wire

// ---- src/simd_fma_operand_decode.sv ----
// SIMD fused multiply-add operand and option decoder with Avalon-MM
// register slave and sticky-event interrupt.
// Assumes instruction inputs are synchronous to clk_sys and that the
// arithmetic datapath downstream reports exceptions on exc_valid.
// Functional notes
// - Basic and extended lanes decode as two independent operations.
// - Ordinary SIMD basic lane forces register-number top bit to zero.
// - With SIMD off, every operand reaches the whole register file.
// - FMA double sources one and two address any even register, extended inverts bit 8.
// - Source-one prefix top bit is bit 8 basic, inverted for extended.
// - Source-two prefix top bit decodes exactly like source one.
// - FMA third source and destination stay in their lane's half.
// - Third source and destination number: lane bit, prefix 1:0, field.
// - Top prefix bit of third source and destination selects no register.
// - Third-source top prefix bit makes extended lane reuse basic source one.
// - Destination top prefix bit negates the extended-lane product only.
// - Size 11 with var not 11 traps illegal, skipping float-off check.
// - Raises float-off, IEEE and miscellaneous incomplete-operation traps.
// - Each lane is fused: exact product, one final rounding.
// - Var picks add, subtract, negative forms; size picks single or double.
// - Negative forms negate the product before adding or subtracting.
`timescale 1ns/100ps
`default_nettype none
`include "fma_decode_defines.svh"
module simd_fma_operand_decode (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire fma_decode_pkg::prefix_s prefix_bits,
  input wire logic simd_lane_enable,
  output logic dec_valid,
  output logic dec_fma,
  output logic dec_double,
  output fma_decode_pkg::regs_s basic_regs,
  output fma_decode_pkg::regs_s ext_regs,
  output fma_decode_pkg::lane_op_s basic_op,
  output fma_decode_pkg::lane_op_s ext_op,
  output logic illegal_trap,
  output logic float_unit_off_trap,
  input wire logic exc_valid,
  input wire fma_decode_pkg::ieee_s exc_flags,
  input wire logic exc_incomplete,
  output logic ieee_trap,
  output fma_decode_pkg::ieee_s ieee_trap_cause,
  output logic float_misc_trap,
  output logic [2:0] float_trap_type
);
  import fma_decode_pkg::*;

  // Double registers fold the low field bit into the top of the 6-bit field
  function automatic logic [5:0] field6(input logic [4:0] rs, input logic dbl);
    field6 = dbl ? {rs[0], rs[4:1], 1'b0} : {1'b0, rs};
  endfunction : field6

  logic [31:0] ctrl_ff;
  logic [`EVT_W-1:0] status_ff;
  logic [`EVT_W-1:0] mask_ff;
  logic [31:0] info_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic acc;
  logic [31:0] rd_mux;
  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] rd_clear;

  logic [1:0] var_f;
  logic [1:0] size_f;
  logic opc_hit;
  logic fma_hit;
  logic rsvd_hit;
  logic dbl;
  logic share;
  logic negx;
  logic [5:0] fld [4];
  logic [2:0] pfx [4];
  reg_num_t bnum [4];
  reg_num_t enum_ [4];
  logic [3:0] pair_sel;
  ieee_s tem;
  ieee_s trap_hit;

  // Avalon slave: one wait cycle, then answer
  assign req = avs_read | avs_write;
  assign acc = req & ack_ff;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) ack_ff <= 1'b0;
    else ack_ff <= req & ~ack_ff;
  end

  always_comb begin
    case (avs_address)
      `REG_CTRL: rd_mux = ctrl_ff;
      `REG_STATUS: rd_mux = {28'h000_0000, status_ff};
      `REG_MASK: rd_mux = {28'h000_0000, mask_ff};
      `REG_INFO: rd_mux = info_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle stays until the next read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) rdata_ff <= 32'h0000_0000;
    else if (avs_read && !ack_ff) rdata_ff <= rd_mux;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) ctrl_ff <= `CTRL_RESET;
    else if (acc && avs_write && avs_address == `REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) ctrl_ff[b*8 +: 8] <= avs_writedata[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) mask_ff <= '0;
    else if (acc && avs_write && avs_address == `REG_MASK && avs_byteenable[0])
      mask_ff <= avs_writedata[`EVT_W-1:0];
  end

  // Only bits the reader actually saw are cleared; a new event wins
  assign rd_clear = (acc && avs_read && avs_address == `REG_STATUS) ?
                    rdata_ff[`EVT_W-1:0] : '0;

  always_comb begin
    evt_set = '0;
    evt_set[`EVT_ILLEGAL] = illegal_trap;
    evt_set[`EVT_FPOFF] = float_unit_off_trap;
    evt_set[`EVT_IEEE] = ieee_trap;
    evt_set[`EVT_MISC] = float_misc_trap;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) status_ff <= '0;
    else status_ff <= (status_ff & ~rd_clear) | evt_set;
  end

  assign irq = |(status_ff & mask_ff);

  // Instruction field decode
  assign var_f = instr_word[`VAR_MSB:`VAR_LSB];
  assign size_f = instr_word[`SIZE_MSB:`SIZE_LSB];
  assign opc_hit = instr_word[`OP_MSB:`OP_LSB] == `OP_FMA &&
                   instr_word[`OP3_MSB:`OP3_LSB] == `OP3_FMA;
  assign rsvd_hit = opc_hit && size_f == `SIZE_RSVD && var_f != `VAR_RSVD;
  assign fma_hit = opc_hit && (size_f == `SIZE_SINGLE || size_f == `SIZE_DOUBLE);
  assign dbl = size_f == `SIZE_DOUBLE;
  // Options exist only for SIMD FMA; ignored elsewhere as software zeroes them
  assign share = simd_lane_enable & fma_hit &
                 prefix_bits.src3_prefix_bits[`PFX_HI];
  assign negx = simd_lane_enable & fma_hit &
                prefix_bits.dest_prefix_bits[`PFX_HI];

  assign fld[0] = field6(instr_word[`RS1_MSB:`RS1_LSB], dbl);
  assign fld[1] = field6(instr_word[`RS2_MSB:`RS2_LSB], dbl);
  assign fld[2] = field6(instr_word[`RS3_MSB:`RS3_LSB], dbl);
  assign fld[3] = field6(instr_word[`RD_MSB:`RD_LSB], dbl);
  assign pfx[0] = prefix_bits.src1_prefix_bits;
  assign pfx[1] = prefix_bits.src2_prefix_bits;
  assign pfx[2] = prefix_bits.src3_prefix_bits;
  assign pfx[3] = prefix_bits.dest_prefix_bits;
  assign pair_sel = 4'h3;

  // One lane map per operand, both lanes side by side
  for (genvar g = 0; g < 4; g++) begin : g_opnd
    operand_lane_map u_map (
      .prefix(pfx[g]),
      .field(fld[g]),
      .simd(simd_lane_enable),
      .fma(fma_hit),
      .pair_src(pair_sel[g]),
      .basic_num(bnum[g]),
      .ext_num(enum_[g])
    );
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) dec_valid <= 1'b0;
    else dec_valid <= instr_valid & fma_hit & ctrl_ff[`CTRL_FPEN];
  end

  // Register numbers for both lanes leave together
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      basic_regs <= '0;
      ext_regs <= '0;
      dec_fma <= 1'b0;
      dec_double <= 1'b0;
    end else if (instr_valid) begin
      basic_regs <= '{bnum[0], bnum[1], bnum[2], bnum[3]};
      ext_regs.src1 <= share ? bnum[0] : enum_[0];
      ext_regs.src2 <= enum_[1];
      ext_regs.src3 <= enum_[2];
      ext_regs.dest <= enum_[3];
      dec_fma <= fma_hit;
      dec_double <= dbl;
    end
  end

  // Datapath keeps the product exact and rounds once per lane
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      basic_op <= '0;
      ext_op <= '0;
    end else if (instr_valid) begin
      basic_op <= '{var_f[1], var_f[0]};
      ext_op <= '{var_f[1] ^ negx, var_f[0]};
    end
  end

  // Illegal encoding outranks the float-off check
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      illegal_trap <= 1'b0;
      float_unit_off_trap <= 1'b0;
    end else begin
      illegal_trap <= instr_valid & rsvd_hit;
      float_unit_off_trap <= instr_valid & fma_hit & ~ctrl_ff[`CTRL_FPEN];
    end
  end

  assign tem = ctrl_ff[`CTRL_TEM_MSB:`CTRL_TEM_LSB];
  assign trap_hit = exc_flags & tem;

  // Incomplete operation preempts IEEE reporting for the same result
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ieee_trap <= 1'b0;
      ieee_trap_cause <= '0;
      float_misc_trap <= 1'b0;
      float_trap_type <= `TRAP_TYPE_NONE;
    end else begin
      ieee_trap <= exc_valid & ~exc_incomplete & (|trap_hit);
      ieee_trap_cause <= (exc_valid & ~exc_incomplete) ? trap_hit : '0;
      float_misc_trap <= exc_valid & exc_incomplete;
      if (exc_valid && exc_incomplete) float_trap_type <= `TRAP_TYPE_INCOMPLETE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) info_ff <= '0;
    else if (instr_valid && opc_hit)
      info_ff <= {24'h00_0000, simd_lane_enable, rsvd_hit, negx, share,
                  dbl, fma_hit, var_f};
  end

  chk_ext_src1_inv: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && simd_lane_enable && fma_hit && !share |=>
    ext_regs.src1[8] == !basic_regs.src1[8] &&
    ext_regs.src1[7:0] == basic_regs.src1[7:0])
    else $error("extended source one does not invert bit 8");

  chk_ext_src2_inv: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && simd_lane_enable && fma_hit |=>
    ext_regs.src2 == {!basic_regs.src2[8], basic_regs.src2[7:0]})
    else $error("extended source two does not invert bit 8");

  chk_share_src1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && share |=> ext_regs.src1 == basic_regs.src1)
    else $error("shared source one not used by extended lane");

  chk_third_lane_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && simd_lane_enable |=>
    !basic_regs.src3[8] && ext_regs.src3[8] &&
    !basic_regs.dest[8] && ext_regs.dest[8])
    else $error("third source or destination left its lane half");

  chk_dest_layout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && simd_lane_enable |=>
    basic_regs.dest[7:6] == $past(prefix_bits.dest_prefix_bits[1:0]) &&
    basic_regs.dest[5:0] == $past(fld[3]))
    else $error("destination number layout wrong");

  chk_nosimd_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && !simd_lane_enable |=>
    basic_regs.src3 == {$past(prefix_bits.src3_prefix_bits), $past(fld[2])})
    else $error("register range restricted with SIMD off");

  chk_ext_negate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid |=> ext_op.neg_product == (basic_op.neg_product ^ $past(negx)) &&
    ext_op.sub_addend == basic_op.sub_addend)
    else $error("extended product sign wrong");

  chk_illegal_trap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && rsvd_hit |=> illegal_trap && !float_unit_off_trap)
    else $error("reserved size not trapped illegal");

  chk_fpoff_trap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && fma_hit && !ctrl_ff[`CTRL_FPEN] |=>
    float_unit_off_trap && !dec_valid)
    else $error("float unit off not trapped");

  chk_misc_type: assert property (@(posedge clk_sys) disable iff (!rst_n)
    exc_valid && exc_incomplete |=>
    float_misc_trap && !ieee_trap && float_trap_type == `TRAP_TYPE_INCOMPLETE)
    else $error("incomplete operation trap wrong");

  chk_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in one wait cycle");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(illegal_trap) && mask_ff[`EVT_ILLEGAL] |=> irq)
    else $error("masked-in event did not raise irq");

  chk_plain_top_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instr_valid && simd_lane_enable && !fma_hit |=>
    !basic_regs.src1[8] && !basic_regs.src2[8] && ext_regs.src1[8] && ext_regs.src2[8])
    else $error("plain SIMD basic lane reached the upper half");

  // A status bit may only drop when a read returned it
  chk_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (status_ff != '0) |=> (status_ff & $past(status_ff) & ~$past(rd_clear)) ==
    ($past(status_ff) & ~$past(rd_clear)))
    else $error("status bit lost without a read");

  chk_trap_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(illegal_trap && float_unit_off_trap))
    else $error("illegal and float-off traps raised together");

  cov_share: cover property (@(posedge clk_sys) instr_valid && share && negx);
  cov_plain_simd: cover property (@(posedge clk_sys) instr_valid && simd_lane_enable && !fma_hit);
  cov_illegal: cover property (@(posedge clk_sys) illegal_trap);
  cov_status_read: cover property (@(posedge clk_sys) |rd_clear);
  cov_double_fma: cover property (@(posedge clk_sys) dec_valid && dec_double);

endmodule : simd_fma_operand_decode
`default_nettype wire

// ---- tb/simd_fma_operand_decode_tb.sv ----
// Self-checking bench for the SIMD fused multiply-add operand decoder.
// Assumes the design package and defines header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "fma_decode_defines.svh"
module simd_fma_operand_decode_tb;
  import fma_decode_pkg::*;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq, instr_valid;
  logic simd_lane_enable, dec_valid, dec_fma, dec_double, illegal_trap;
  logic float_unit_off_trap, exc_valid, exc_incomplete, ieee_trap, float_misc_trap;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, instr_word, seed, r, q;
  logic [3:0] avs_byteenable, en, st;
  logic [2:0] float_trap_type;
  logic [1:0] sz;
  prefix_s prefix_bits, p;
  regs_s basic_regs, ext_regs, eb, ee;
  lane_op_s basic_op, ext_op;
  ieee_s exc_flags, ieee_trap_cause;
  int fail_count, samples_checked;

  simd_fma_operand_decode dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .instr_valid,
    .instr_word, .prefix_bits, .simd_lane_enable, .dec_valid, .dec_fma, .dec_double,
    .basic_regs, .ext_regs, .basic_op, .ext_op, .illegal_trap, .float_unit_off_trap,
    .exc_valid, .exc_flags, .exc_incomplete, .ieee_trap, .ieee_trap_cause,
    .float_misc_trap, .float_trap_type);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Request held until waitrequest is seen low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) fail_count++;
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(q, exp);
  endtask : rdchk

  task automatic issue(input logic [31:0] w, input logic sm);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    prefix_bits <= p;
    simd_lane_enable <= sm;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic exc(input logic [3:0] f, input logic inc);
    @(posedge clk_sys);
    exc_valid <= 1'b1;
    exc_flags <= f;
    exc_incomplete <= inc;
    @(posedge clk_sys);
    exc_valid <= 1'b0;
    #1;
  endtask : exc

  function automatic reg_num_t rn(input logic [2:0] pf, input logic [4:0] rs,
      input logic pair, input logic ext);
    logic [5:0] f6;
    f6 = sz[1] ? {rs[0], rs[4:1], 1'b0} : {1'b0, rs};
    if (!q[12]) return {pf, f6};
    if (pair) return {pf[2] ^ ext, pf[1:0], f6};
    return {ext, pf[1:0], f6};
  endfunction : rn

  function automatic regs_s er(input logic ext);
    regs_s x;
    x.src1 = rn(p.src1_prefix_bits, r[18:14], 1'b1, ext);
    x.src2 = rn(p.src2_prefix_bits, r[4:0], 1'b1, ext);
    x.src3 = rn(p.src3_prefix_bits, r[13:9], 1'b0, ext);
    x.dest = rn(p.dest_prefix_bits, r[29:25], 1'b0, ext);
    return x;
  endfunction : er

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    seed = 32'h0000_d6db;
    fail_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    instr_valid = 1'b0;
    instr_word = '0;
    prefix_bits = '0;
    simd_lane_enable = 1'b0;
    exc_valid = 1'b0;
    exc_flags = '0;
    exc_incomplete = 1'b0;
    p = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk({irq, dec_valid, ieee_trap, float_trap_type}, 64'h0);
    rdchk(`REG_CTRL, 32'h0000_0001);
    bus(1'b1, 5'h10, 32'hffff_ffff, 4'hf);
    rdchk(5'h10, 32'h0000_0000);
    bus(1'b1, `REG_MASK, 32'h0000_000f, 4'he);
    rdchk(`REG_MASK, 32'h0000_0000);
    // Only FMA encodings are sent, so option bits are legal everywhere
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      q = rnd();
      p = q[11:0];
      sz = r[5] ? `SIZE_DOUBLE : `SIZE_SINGLE;
      issue({`OP_FMA, r[29:25], `OP3_FMA, r[18:14], r[13:9], r[8:7], sz, r[4:0]}, q[12]);
      eb = er(1'b0);
      ee = er(1'b1);
      if (q[12] && p.src3_prefix_bits[2]) ee.src1 = eb.src1;
      chk(basic_regs, eb);
      chk(ext_regs, ee);
      chk(basic_op, r[8:7]);
      chk(ext_op, {r[8] ^ (q[12] & p.dest_prefix_bits[2]), r[7]});
      chk({dec_valid, dec_fma, dec_double, illegal_trap, float_unit_off_trap},
        {2'b11, sz[1], 2'b00});
    end
    // Float unit off: reserved size must still trap illegal, not float-off
    bus(1'b1, `REG_CTRL, 32'h0000_0000, 4'hf);
    p = '0;
    for (int v = 0; v < 4; v++) begin
      issue({`OP_FMA, 5'h01, `OP3_FMA, 10'h000, v[1:0], `SIZE_RSVD, 5'h02}, 1'b0);
      chk({dec_valid, illegal_trap, float_unit_off_trap}, {1'b0, v != 3, 1'b0});
    end
    issue({`OP_FMA, 5'h01, `OP3_FMA, 10'h000, 2'h0, `SIZE_SINGLE, 5'h02}, 1'b1);
    chk({dec_valid, illegal_trap, float_unit_off_trap}, 3'b001);
    st = 4'h3;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(irq, 1'b0);
    bus(1'b1, `REG_MASK, 32'h0000_000f, 4'h1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq, 1'b1);
    rdchk(`REG_STATUS, {28'h000_0000, st});
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq, 1'b0);
    rdchk(`REG_STATUS, 32'h0000_0000);
    // Partial trap enables show which flags are allowed through
    en = 4'b0101;
    bus(1'b1, `REG_CTRL, {27'h000_0000, en, 1'b1}, 4'hf);
    rdchk(`REG_CTRL, {27'h000_0000, en, 1'b1});
    for (int f = 1; f < 16; f++) begin
      exc(f[3:0], 1'b0);
      chk({ieee_trap, ieee_trap_cause, float_misc_trap},
        {|(f[3:0] & en), f[3:0] & en, 1'b0});
    end
    chk(float_trap_type, `TRAP_TYPE_NONE);
    exc(4'hf, 1'b1);
    chk({ieee_trap, float_misc_trap, float_trap_type},
      {2'b01, `TRAP_TYPE_INCOMPLETE});
    repeat (3) @(posedge clk_sys);
    #1;
    rdchk(`REG_STATUS, 32'h0000_000c);
    // Plain SIMD encoding with every prefix bit set: basic lane low half only, no options
    p = 12'hfff;
    issue({`OP_FMA, 5'h01, `OP3_FMA, 5'h01, 5'h00, 2'h0, `SIZE_RSVD, 5'h02}, 1'b1);
    chk({illegal_trap, basic_regs.src1, ext_regs.src1}, {1'b1, 9'h0c1, 9'h1c1});
    chk({basic_regs.src2, ext_op}, {9'h0c2, 2'b00});
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq, 1'b1);
    rdchk(`REG_STATUS, 32'h0000_0001);
    rdchk(`REG_INFO, 32'h0000_00c0);
    stop_test();
  end
endmodule : simd_fma_operand_decode_tb
`default_nettype wire
